// ---- logic/cpu_regs_defines.svh ----
// Purpose: offsets, field positions, reset values for the cpu register block
// Assumes: 32-bit ahb-lite data, one aligned word per register
// Notes:   included by the design files
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH

// ====================
// register byte offsets
`define OFS_PC            12'h020
`define OFS_EXT_CTRL      12'h024
`define OFS_COND_CODE     12'h028
`define OFS_FETCH_ADDR    12'h02C
`define OFS_MODE          12'h030

// ====================
// condition-code field positions
`define CC_IMASK          7
`define CC_USER           6
`define CC_HALF           5
`define CC_NEG            3
`define CC_ZERO           2
`define CC_OVF            1
`define CC_CARRY          0

// ====================
// extended control fields and reset values
`define EXT_TRACE         7
`define EXT_RO_MASK       8'h78
`define EXT_RESET         8'h07
`define CC_RESET          8'h80
`define PC_RESET          24'h000000
`define SP_INDEX          3'h7

`endif

// ---- logic/cpu_regs_pkg.sv ----
// Purpose: shared types for the cpu register block
// Assumes: constants come from cpu_regs_defines.svh
// Notes:   types only
`default_nettype none
package cpu_regs_pkg;
    // access width of a general register view
    typedef enum logic [1:0] {
        acc_long_t_val  = 2'h0,
        acc_upper_t_val = 2'h1,
        acc_lower_t_val = 2'h2,
        acc_byte_t_val  = 2'h3
    } acc_width_t;
    // alu operation sizes for flag generation
    typedef enum logic [1:0] {
        sz_byte = 2'h0,
        sz_word = 2'h1,
        sz_long = 2'h2
    } op_size_t;
    // condition-code logic operations
    typedef enum logic [2:0] {
        cc_op_none  = 3'h0,
        cc_op_load  = 3'h1,
        cc_op_and   = 3'h2,
        cc_op_or    = 3'h3,
        cc_op_xor   = 3'h4
    } cc_op_t;
endpackage
`default_nettype wire

// ---- logic/gpr_bank.sv ----
// Purpose: eight 32-bit general registers with width views
// Assumes: one write port, two read ports, single clock
// Notes:   register 7 doubles as the stack pointer
`default_nettype none
`include "cpu_regs_defines.svh"
module gpr_bank
    import cpu_regs_pkg::*;
#(
    parameter int NUM_REGS = 8
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic        wr_hi_byte,
    input  wire logic [1:0]  wr_width,
    input  wire logic [31:0] wr_data,
    input  wire logic [2:0]  rd_idx,
    input  wire logic [1:0]  rd_width,
    input  wire logic        rd_hi_byte,
    input  wire logic [2:0]  bus_rd_idx,
    output logic      [31:0] bus_rd_data,
    output logic      [31:0] rd_data,
    output logic      [31:0] stack_pointer
);
    if (NUM_REGS != 8) begin : g_bad_count
        $error("gpr_bank serves exactly 8 registers");
    end

    logic [31:0] gpr_reg [NUM_REGS];

    // ====================
    // width view extraction, zero-extended
    function automatic logic [31:0] view(input logic [31:0] r,
                                         input logic [1:0] w,
                                         input logic hi);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (acc_width_t'(w))
            acc_long_t_val:  v = r;
            acc_upper_t_val: v = {16'h0000, r[31:16]};
            acc_lower_t_val: v = {16'h0000, r[15:0]};
            acc_byte_t_val:  v = hi ? {24'h0, r[15:8]} : {24'h0, r[7:0]};
        endcase
        return v;
    endfunction

    // ====================
    // writes touch only the addressed bits of one register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_REGS; i++) gpr_reg[i] <= 32'h0000_0000;
        end else if (wr_en) begin
            unique case (acc_width_t'(wr_width))
                acc_long_t_val:  gpr_reg[wr_idx] <= wr_data;
                acc_upper_t_val: gpr_reg[wr_idx][31:16] <= wr_data[15:0];
                acc_lower_t_val: gpr_reg[wr_idx][15:0] <= wr_data[15:0];
                acc_byte_t_val: begin
                    if (wr_hi_byte) gpr_reg[wr_idx][15:8] <= wr_data[7:0];
                    else gpr_reg[wr_idx][7:0] <= wr_data[7:0];
                end
            endcase
        end
    end

    always_comb begin
        rd_data = view(gpr_reg[rd_idx], rd_width, rd_hi_byte);
    end

    assign stack_pointer = gpr_reg[`SP_INDEX];
    // bus reads get their own port so they never follow the exec select
    assign bus_rd_data   = gpr_reg[bus_rd_idx];
endmodule
`default_nettype wire

// ---- logic/cc_flags.sv ----
// Purpose: flag generation from an alu result
// Assumes: caller supplies operands, size and subtract select
// Notes:   purely combinational
`default_nettype none
`include "cpu_regs_defines.svh"
module cc_flags
    import cpu_regs_pkg::*;
(
    input  wire logic [1:0]  size,
    input  wire logic [31:0] op_a,
    input  wire logic [31:0] op_b,
    input  wire logic        subtract,
    output logic      [31:0] result,
    output logic      [3:0]  nzvc,
    output logic             half
);
    logic [32:0] sum;
    logic [31:0] b_eff;
    logic [4:0]  h3;
    logic [12:0] h11;
    logic [28:0] h27;
    logic        msb, amsb, bmsb, cy;

    always_comb begin
        b_eff = subtract ? ~op_b : op_b;
        sum = {1'b0, op_a} + {1'b0, b_eff} + {32'h0, subtract};
        h3  = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, subtract};
        h11 = {1'b0, op_a[11:0]} + {1'b0, b_eff[11:0]} + {12'h0, subtract};
        h27 = {1'b0, op_a[27:0]} + {1'b0, b_eff[27:0]} + {28'h0, subtract};
        result = sum[31:0];
        msb = 1'b0;
        amsb = 1'b0;
        bmsb = 1'b0;
        cy = 1'b0;
        half = 1'b0;
        unique case (op_size_t'(size))
            sz_byte: begin
                result = {24'h0, sum[7:0]};
                msb = sum[7];
                amsb = op_a[7];
                bmsb = b_eff[7];
                cy = ({1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]}
                      + {8'h0, subtract}) > 9'h0FF;
                half = h3[4] ^ subtract;
            end
            sz_word: begin
                result = {16'h0, sum[15:0]};
                msb = sum[15];
                amsb = op_a[15];
                bmsb = b_eff[15];
                cy = ({1'b0, op_a[15:0]} + {1'b0, b_eff[15:0]}
                      + {16'h0, subtract}) > 17'h0FFFF;
                half = h11[12] ^ subtract;
            end
            sz_long: begin
                msb = sum[31];
                amsb = op_a[31];
                bmsb = b_eff[31];
                cy = sum[32];
                half = h27[28] ^ subtract;
            end
            default: ;
        endcase
        // borrow is the inverse of carry when subtracting
        nzvc[3] = msb;
        nzvc[2] = (result == 32'h0);
        nzvc[1] = (amsb == bmsb) && (msb != amsb);
        nzvc[0] = cy ^ subtract;
    end
endmodule
`default_nettype wire

// ---- logic/cpu_regs.sv ----
// Purpose: programmer-visible register set with ahb-lite access
// Assumes: execution logic drives the exec port; one clock
// Notes:   bus writes lose to exec writes; exec writes win on same cycle
//
// Behaviour
// - eight identical 32-bit general registers
// - 32-bit register splits into two 16-bit halves
// - lower half splits into two bytes
// - access width chosen per register independently
// - register seven is also the stack pointer
// - holds program counter, extended control, condition code
// - program counter addresses next instruction
// - fetch address ignores program counter bit zero
// - trace bit and mask bits, no effect
// - extended control bits 6..3 read one
// - interrupt mask blocks maskable, not nmi
// - exception start sets interrupt mask
// - user bit readable and writable by insns
// - load, store, and, or, xor; nzvc branch
// - linear address 64k normal, 16M advanced
// - half carry from bit 3, 11, 27
// - negative flag copies result sign bit
// - zero flag set on zero result
// - overflow flag set on arithmetic overflow
`default_nettype none
`include "cpu_regs_defines.svh"
module cpu_regs
    import cpu_regs_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // general register port from execution
    input  wire logic        gpr_wr_en,
    input  wire logic [2:0]  gpr_wr_idx,
    input  wire logic [1:0]  gpr_wr_width,
    input  wire logic        gpr_wr_hi_byte,
    input  wire logic [31:0] gpr_wr_data,
    input  wire logic [2:0]  gpr_rd_idx,
    input  wire logic [1:0]  gpr_rd_width,
    input  wire logic        gpr_rd_hi_byte,
    output logic      [31:0] gpr_rd_data,
    output logic      [31:0] stack_pointer,
    // program counter
    input  wire logic        pc_load,
    input  wire logic [23:0] pc_load_value,
    input  wire logic        pc_advance,
    output logic      [23:0] program_counter,
    output logic      [23:0] fetch_addr,
    // condition code
    input  wire logic [2:0]  cc_op,
    input  wire logic [7:0]  cc_operand,
    input  wire logic        alu_flags_en,
    input  wire logic [1:0]  alu_size,
    input  wire logic [31:0] alu_a,
    input  wire logic [31:0] alu_b,
    input  wire logic        alu_sub,
    output logic      [31:0] alu_result,
    input  wire logic        exception_start,
    input  wire logic        irq_pending,
    input  wire logic        nmi_pending,
    output logic             irq_accept,
    output logic      [7:0]  condition_code,
    output logic      [7:0]  extended_control,
    // operating mode and addressing
    input  wire logic        advanced_mode,
    input  wire logic [31:0] ea_in,
    output logic      [23:0] ea_out
);
    // ====================
    // local state
    logic [23:0] pc_reg;
    logic [7:0]  cc_reg;
    logic [7:0]  ext_reg;
    logic [3:0]  nzvc;
    logic        half;
    logic        bus_wr_pend_reg;
    logic [11:0] bus_addr_reg;
    logic [31:0] bus_rd_next;
    logic [31:0] bus_gpr_rd;
    logic        bus_gpr_wr;
    logic [2:0]  mux_wr_idx;
    logic [1:0]  mux_wr_width;
    logic        mux_wr_hi;
    logic [31:0] mux_wr_data;
    logic        mux_wr_en;
    logic        addr_phase;

    function automatic logic is_gpr(input logic [11:0] a);
        return a[11:5] == 7'h00;
    endfunction

    // ====================
    // general registers
    gpr_bank #(.NUM_REGS(8)) u_gpr (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .wr_en         (mux_wr_en),
        .wr_idx        (mux_wr_idx),
        .wr_hi_byte    (mux_wr_hi),
        .wr_width      (mux_wr_width),
        .wr_data       (mux_wr_data),
        .rd_idx        (gpr_rd_idx),
        .rd_width      (gpr_rd_width),
        .rd_hi_byte    (gpr_rd_hi_byte),
        .bus_rd_idx    (haddr[4:2]),
        .bus_rd_data   (bus_gpr_rd),
        .rd_data       (gpr_rd_data),
        .stack_pointer (stack_pointer)
    );

    // ====================
    // alu flag generation
    cc_flags u_flags (
        .size     (alu_size),
        .op_a     (alu_a),
        .op_b     (alu_b),
        .subtract (alu_sub),
        .result   (alu_result),
        .nzvc     (nzvc),
        .half     (half)
    );

    // ====================
    // ahb-lite slave: zero wait, always okay
    assign addr_phase = hsel && hready && htrans[1];
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_wr_pend_reg <= 1'b0;
            bus_addr_reg    <= 12'h000;
        end else if (hready) begin
            bus_wr_pend_reg <= addr_phase && hwrite;
            bus_addr_reg    <= haddr;
        end
    end

    // bus writes to general registers use the full word view;
    // execution has priority so an instruction is never stalled
    assign bus_gpr_wr   = bus_wr_pend_reg && is_gpr(bus_addr_reg);
    assign mux_wr_en    = gpr_wr_en || bus_gpr_wr;
    assign mux_wr_idx   = gpr_wr_en ? gpr_wr_idx : bus_addr_reg[4:2];
    assign mux_wr_width = gpr_wr_en ? gpr_wr_width : 2'h0;
    assign mux_wr_hi    = gpr_wr_en ? gpr_wr_hi_byte : 1'b0;
    assign mux_wr_data  = gpr_wr_en ? gpr_wr_data : hwdata;

    // read data registered in the address phase
    always_comb begin
        bus_rd_next = 32'h0000_0000;
        if (is_gpr(haddr)) begin
            bus_rd_next = bus_gpr_rd;
        end else begin
            unique case (haddr)
                `OFS_PC:         bus_rd_next = {8'h00, pc_reg};
                `OFS_EXT_CTRL:   bus_rd_next = {24'h0, ext_reg | `EXT_RO_MASK};
                `OFS_COND_CODE:  bus_rd_next = {24'h0, cc_reg};
                `OFS_FETCH_ADDR: bus_rd_next = {8'h00, fetch_addr};
                `OFS_MODE:       bus_rd_next = {31'h0, advanced_mode};
                default:         bus_rd_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            hrdata <= bus_rd_next;
        end
    end

    // ====================
    // program counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_reg <= `PC_RESET;
        end else if (pc_load) begin
            pc_reg <= pc_load_value;
        end else if (pc_advance) begin
            pc_reg <= pc_reg + 24'h000002;
        end else if (bus_wr_pend_reg && bus_addr_reg == `OFS_PC) begin
            pc_reg <= hwdata[23:0];
        end
    end
    assign program_counter = pc_reg;
    assign fetch_addr      = {pc_reg[23:1], 1'b0};

    // ====================
    // extended control: stored only, steers nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_reg <= `EXT_RESET;
        end else if (bus_wr_pend_reg && bus_addr_reg == `OFS_EXT_CTRL) begin
            ext_reg <= hwdata[7:0] & ~`EXT_RO_MASK;
        end
    end
    assign extended_control = ext_reg | `EXT_RO_MASK;

    // ====================
    // condition code; user bit resets to zero as a safe choice
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc_reg <= `CC_RESET;
        end else if (exception_start) begin
            cc_reg[`CC_IMASK] <= 1'b1;
        end else if (cc_op != 3'(cc_op_none)) begin
            unique case (cc_op_t'(cc_op))
                cc_op_load: cc_reg <= cc_operand;
                cc_op_and:  cc_reg <= cc_reg & cc_operand;
                cc_op_or:   cc_reg <= cc_reg | cc_operand;
                cc_op_xor:  cc_reg <= cc_reg ^ cc_operand;
                default:    cc_reg <= cc_reg;
            endcase
        end else if (alu_flags_en) begin
            cc_reg[`CC_HALF]  <= half;
            cc_reg[`CC_NEG]   <= nzvc[3];
            cc_reg[`CC_ZERO]  <= nzvc[2];
            cc_reg[`CC_OVF]   <= nzvc[1];
            cc_reg[`CC_CARRY] <= nzvc[0];
        end else if (bus_wr_pend_reg && bus_addr_reg == `OFS_COND_CODE) begin
            cc_reg <= hwdata[7:0];
        end
    end
    assign condition_code = cc_reg;

    // nmi bypasses the mask
    assign irq_accept = nmi_pending
                      || (irq_pending && !cc_reg[`CC_IMASK]);

    // ====================
    // linear effective address per mode
    assign ea_out = advanced_mode ? ea_in[23:0]
                                  : {8'h00, ea_in[15:0]};
endmodule
`default_nettype wire

// ---- dv/cpu_regs_assertions.sv ----
// Purpose: concurrent checks on the cpu register block ports
// Assumes: one clock hclk, async active-low hresetn
// Notes:   bound into cpu_regs at the foot of this file
`default_nettype none
module cpu_regs_checker
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        pc_load,
    input  wire logic [23:0] pc_load_value,
    input  wire logic        pc_advance,
    input  wire logic [23:0] program_counter,
    input  wire logic [23:0] fetch_addr,
    input  wire logic [2:0]  cc_op,
    input  wire logic [7:0]  cc_operand,
    input  wire logic        exception_start,
    input  wire logic        irq_pending,
    input  wire logic        nmi_pending,
    input  wire logic        irq_accept,
    input  wire logic [7:0]  condition_code,
    input  wire logic [7:0]  extended_control,
    input  wire logic [2:0]  gpr_rd_idx,
    input  wire logic [1:0]  gpr_rd_width,
    input  wire logic [31:0] gpr_rd_data,
    input  wire logic [31:0] stack_pointer,
    input  wire logic        advanced_mode,
    input  wire logic [31:0] ea_in,
    input  wire logic [23:0] ea_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dck @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ====================
    // program counter
    a_fetch_addr_even: assert property (
        fetch_addr == {program_counter[23:1], 1'b0})
        else $error("fetch address not the even pc");
    a_pc_step_two: assert property (
        pc_advance && !pc_load |=>
        program_counter == $past(program_counter) + 24'h000002)
        else $error("pc did not advance by two");
    a_pc_load_lands: assert property (
        pc_load |=> program_counter == $past(pc_load_value))
        else $error("pc load value not taken");
    // ====================
    // control registers
    a_ext_reads_one: assert property (
        extended_control[6:3] == 4'hF)
        else $error("extended control fixed bits not one");
    a_exc_sets_mask: assert property (
        exception_start |=> condition_code[7])
        else $error("exception did not set the mask");
    a_cc_xor_op: assert property (
        cc_op == 3'h4 && !exception_start |=>
        condition_code == ($past(condition_code) ^ $past(cc_operand)))
        else $error("cc xor result wrong");
    // nmi ignores the mask
    a_nmi_always: assert property (
        nmi_pending |-> irq_accept)
        else $error("nmi not accepted");
    a_irq_masked: assert property (
        irq_pending && !nmi_pending |-> irq_accept == !condition_code[7])
        else $error("irq accept ignores mask");
    // ====================
    // general registers and addressing
    a_sp_is_gpr7: assert property (
        gpr_rd_idx == 3'h7 && gpr_rd_width == 2'h0 |->
        gpr_rd_data == stack_pointer)
        else $error("stack pointer differs from register seven");
    a_ea_range: assert property (
        ea_out == (advanced_mode ? ea_in[23:0] : {8'h00, ea_in[15:0]}))
        else $error("effective address range wrong");
endmodule
bind cpu_regs cpu_regs_checker chk (.*);
`default_nettype wire

// ---- dv/exec_model.sv ----
// Purpose: execution-side model driving the register block
// Assumes: each request is set after a rising edge; all but rs and lv are held one cycle
// Notes:   released data buses show inverted data, not the last value
`default_nettype none
module exec_model
    import cpu_regs_pkg::*;
(
    input  wire logic   hclk,
    output logic        gpr_wr_en,
    output logic [2:0]  gpr_wr_idx,
    output logic [1:0]  gpr_wr_width,
    output logic        gpr_wr_hi_byte,
    output logic [31:0] gpr_wr_data,
    output logic [2:0]  gpr_rd_idx,
    output logic [1:0]  gpr_rd_width,
    output logic        gpr_rd_hi_byte,
    output logic        pc_load,
    output logic [23:0] pc_load_value,
    output logic        pc_advance,
    output logic [2:0]  cc_op,
    output logic [7:0]  cc_operand,
    output logic        alu_flags_en,
    output logic [1:0]  alu_size,
    output logic [31:0] alu_a,
    output logic [31:0] alu_b,
    output logic        alu_sub,
    output logic        exception_start,
    output logic        irq_pending,
    output logic        nmi_pending,
    output logic        advanced_mode,
    output logic [31:0] ea_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {gpr_wr_en, gpr_wr_idx, gpr_wr_width, gpr_wr_hi_byte, gpr_wr_data,
         gpr_rd_idx, gpr_rd_width, gpr_rd_hi_byte, pc_load, pc_load_value,
         pc_advance, cc_op, cc_operand, alu_flags_en, alu_size, alu_a,
         alu_b, alu_sub, exception_start, irq_pending, nmi_pending,
         advanced_mode, ea_in} = '0;
    end
    // ====================
    // one-cycle requests except rs and lv, ending at a falling edge
    task automatic gw(input logic [2:0] i, input logic [1:0] w,
                      input logic h, input logic [31:0] d);
        @(posedge hclk);
        {gpr_wr_en, gpr_wr_idx, gpr_wr_width, gpr_wr_hi_byte} <= {1'b1, i, w, h};
        gpr_wr_data <= d;
        @(posedge hclk);
        gpr_wr_en <= 1'b0;
        gpr_wr_data <= ~d;
        @(negedge hclk);
    endtask
    task automatic rs(input logic [2:0] i, input logic [1:0] w,
                      input logic h);
        @(posedge hclk);
        {gpr_rd_idx, gpr_rd_width, gpr_rd_hi_byte} <= {i, w, h};
        @(negedge hclk);
    endtask
    task automatic pl(input logic [23:0] v);
        @(posedge hclk);
        {pc_load, pc_load_value} <= {1'b1, v};
        @(posedge hclk);
        {pc_load, pc_load_value} <= {1'b0, ~v};
        @(negedge hclk);
    endtask
    task automatic pa();
        @(posedge hclk);
        pc_advance <= 1'b1;
        @(posedge hclk);
        pc_advance <= 1'b0;
        @(negedge hclk);
    endtask
    task automatic cc(input logic [2:0] op, input logic [7:0] v);
        @(posedge hclk);
        {cc_op, cc_operand} <= {op, v};
        @(posedge hclk);
        {cc_op, cc_operand} <= {cc_op_none, ~v};
        @(negedge hclk);
    endtask
    task automatic al(input logic [1:0] sz, input logic s,
                      input logic [31:0] a, input logic [31:0] b);
        @(posedge hclk);
        {alu_flags_en, alu_size, alu_sub, alu_a, alu_b} <= {1'b1, sz, s, a, b};
        @(posedge hclk);
        {alu_flags_en, alu_a, alu_b} <= {1'b0, ~a, ~b};
        @(negedge hclk);
    endtask
    task automatic ex();
        @(posedge hclk);
        exception_start <= 1'b1;
        @(posedge hclk);
        exception_start <= 1'b0;
        @(negedge hclk);
    endtask
    task automatic lv(input logic i, input logic n, input logic m,
                      input logic [31:0] e);
        @(posedge hclk);
        {irq_pending, nmi_pending, advanced_mode, ea_in} <= {i, n, m, e};
        @(negedge hclk);
    endtask
endmodule
`default_nettype wire

// ---- dv/cpu_regs_bench.sv ----
// Purpose: self-checking bench for the cpu register block
// Assumes: ahb-lite single word transfers, exec side from exec_model
// Notes:   one idle cycle between bus transfers
`default_nettype none
`include "cpu_regs_defines.svh"
module cpu_regs_bench
    import cpu_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        gpr_wr_en, gpr_wr_hi_byte, gpr_rd_hi_byte, pc_load;
    logic        pc_advance, alu_flags_en, alu_sub, exception_start;
    logic        irq_pending, nmi_pending, irq_accept, advanced_mode;
    logic [1:0]  htrans, gpr_wr_width, gpr_rd_width, alu_size;
    logic [2:0]  hsize, gpr_wr_idx, gpr_rd_idx, cc_op;
    logic [7:0]  cc_operand, condition_code, extended_control;
    logic [11:0] haddr;
    logic [23:0] pc_load_value, program_counter, fetch_addr, ea_out;
    logic [31:0] hwdata, hrdata, gpr_wr_data, gpr_rd_data, stack_pointer;
    logic [31:0] alu_a, alu_b, alu_result, ea_in, rd;
    int          mismatches, n_compared;
    // size, sub, a, b, expected flags outside bit 4
    logic [74:0] at [7] = '{
        {2'h0, 1'b0, 32'h8, 32'h8, 8'h20},
        {2'h0, 1'b0, 32'h80, 32'h80, 8'h07},
        {2'h0, 1'b0, 32'h70, 32'h10, 8'h0A},
        {2'h1, 1'b0, 32'h800, 32'h800, 8'h20},
        {2'h2, 1'b0, 32'h08000000, 32'h08000000, 8'h20},
        {2'h0, 1'b1, 32'h10, 32'h1, 8'h20},
        {2'h2, 1'b1, 32'h0, 32'h1, 8'h29}};
    logic [2:0]  ops [4] = '{cc_op_load, cc_op_and, cc_op_or, cc_op_xor};
    logic [7:0]  opv [4] = '{8'h4F, 8'h43, 8'h84, 8'hFF};
    logic [7:0]  ccx [4] = '{8'h4F, 8'h43, 8'hC7, 8'h38};
    assign hready = hreadyout;
    cpu_regs uut (.*);
    exec_model exec (.*);
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // ====================
    // compare, bus access, closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr, hsize} <= {1'b1, 2'h2, w, a, 3'h2};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans} <= 3'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // tests need under 600 cycles
    initial begin
        #(3000 * 100);
        mismatches++;
        test_done();
    end
    // ====================
    // tests
    initial begin
        {hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
        {hresetn, mismatches, n_compared} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`OFS_EXT_CTRL, 32'h7F);
        rdc(`OFS_COND_CODE, 32'h80);
        rdc(`OFS_PC, 32'h0);
        rdc(12'h100, 32'h0);
        bus(1'b1, `OFS_EXT_CTRL, 32'h0);
        rdc(`OFS_EXT_CTRL, 32'h78);
        bus(1'b1, `OFS_EXT_CTRL, 32'hFF);
        rdc(`OFS_EXT_CTRL, 32'hFF);
        $display("test control_reset done");
        for (int i = 0; i < 8; i++) bus(1'b1, 12'(4 * i), 32'h11111111 * (i + 1));
        for (int i = 0; i < 8; i++) rdc(12'(4 * i), 32'h11111111 * (i + 1));
        chk(stack_pointer, 32'h88888888);
        exec.gw(3'h2, 2'h1, 1'b0, 32'hABCDABCD);
        exec.gw(3'h3, 2'h2, 1'b0, 32'hBEEFBEEF);
        exec.gw(3'h4, 2'h3, 1'b1, 32'h5A5A5A5A);
        exec.gw(3'h5, 2'h3, 1'b0, 32'hC3C3C3C3);
        rdc(12'h008, 32'hABCD3333);
        rdc(12'h00C, 32'h4444BEEF);
        rdc(12'h010, 32'h55555A55);
        rdc(12'h014, 32'h666666C3);
        exec.rs(3'h4, 2'h3, 1'b1);
        chk(gpr_rd_data, 32'h5A);
        exec.rs(3'h2, 2'h1, 1'b0);
        chk(gpr_rd_data, 32'hABCD);
        exec.gw(3'h7, 2'h0, 1'b0, 32'h0000FFFC);
        exec.rs(3'h7, 2'h0, 1'b0);
        chk(stack_pointer, 32'h0000FFFC);
        $display("test general_registers done");
        exec.pl(24'h123457);
        chk({8'h0, program_counter}, 32'h123457);
        chk({8'h0, fetch_addr}, 32'h123456);
        exec.pa();
        chk({8'h0, program_counter}, 32'h123459);
        rdc(`OFS_FETCH_ADDR, 32'h123458);
        $display("test program_counter done");
        for (int i = 0; i < 4; i++) begin
            exec.cc(ops[i], opv[i]);
            chk({24'h0, condition_code}, {24'h0, ccx[i]});
        end
        rdc(`OFS_COND_CODE, 32'h38);
        bus(1'b1, `OFS_COND_CODE, 32'h0);
        exec.ex();
        chk({24'h0, condition_code}, 32'h80);
        exec.lv(1'b1, 1'b0, 1'b0, 32'h12345678);
        chk({31'h0, irq_accept}, 32'h0);
        exec.lv(1'b1, 1'b1, 1'b0, 32'h12345678);
        chk({31'h0, irq_accept}, 32'h1);
        exec.cc(cc_op_load, 8'h00);
        exec.lv(1'b1, 1'b0, 1'b0, 32'h12345678);
        chk({31'h0, irq_accept}, 32'h1);
        chk({8'h0, ea_out}, 32'h00005678);
        exec.lv(1'b0, 1'b0, 1'b1, 32'h12345678);
        chk({8'h0, ea_out}, 32'h00345678);
        $display("test condition_code done");
        for (int i = 0; i < 7; i++) begin
            exec.al(at[i][74:73], at[i][72], at[i][71:40], at[i][39:8]);
            chk({24'h0, condition_code & 8'hEF}, {24'h0, at[i][7:0]});
        end
        $display("test alu_flags done");
        test_done();
    end
endmodule
`default_nettype wire
